// [hw/status_event_pkg.sv]
// Constants, field positions and carrier types for the status and event
// reporting block. Assumes one 250 MHz clock and a synchronous reset.
package status_event_pkg;

	localparam int REG_W = 8;

	// Event flag bit positions
	localparam int EV_ACQ_DONE = 0;
	localparam int EV_STOP = 1;
	localparam int EV_QUERY_ERR = 2;
	localparam int EV_CONFLICT = 3;
	localparam int EV_EXEC_ERR = 4;
	localparam int EV_CMD_ERR = 5;
	localparam int EV_BUF_75 = 6;
	localparam int EV_POWER_ON = 7;

	// Summary status byte bit positions
	localparam int SB_ALARM = 0;
	localparam int SB_TRIG = 1;
	localparam int SB_READY = 2;
	localparam int SB_SCAN = 3;
	localparam int SB_MSG = 4;
	localparam int SB_EVENT_SUM = 5;
	localparam int SB_SRQ = 6;
	localparam int SB_OVERRUN = 7;

	// Error source bit positions
	localparam int ES_CAL = 0;
	localparam int ES_CONFLICT = 1;
	localparam int ES_EXEC = 2;
	localparam int ES_CMD = 3;

	localparam logic [7:0] REG_ZERO = 8'h00;
	localparam logic [7:0] EV_RESET_VAL = 8'h80;
	localparam logic [7:0] MASK_RESET_VAL = 8'h00;

	typedef logic [REG_W-1:0] reg8_t;

	// Controller commands, one-hot except CMD_NONE (all zero)
	typedef enum logic [7:0] {
		CMD_NONE = 8'h00,
		CMD_READ_EVENT = 8'h01,
		CMD_READ_SUMMARY = 8'h02,
		CMD_READ_CAL = 8'h04,
		CMD_READ_ERRSRC = 8'h08,
		CMD_EVMASK_READ = 8'h10,
		CMD_EVMASK_WRITE = 8'h20,
		CMD_SRMASK_READ = 8'h40,
		CMD_SRMASK_WRITE = 8'h80
	} cmd_t;

	typedef struct packed {
		logic valid;
		cmd_t cmd;
		reg8_t data;
	} ctrl_req_t;

	typedef struct packed {
		logic valid;
		reg8_t data;
	} ctrl_rsp_t;

	// Internal device condition inputs
	typedef struct packed {
		reg8_t cal_err;
		logic err_conflict;
		logic err_exec;
		logic err_cmd;
		logic acq_done;
		logic pretrig_met;
		logic new_trig_cfg;
		logic rearm;
		logic query_err;
		logic buf_75;
		logic sys_reset_cmd;
		logic alarm;
		logic trig_detected;
		logic ready;
		logic scan_avail;
		logic msg_waiting;
		logic overrun;
	} dev_events_t;

	typedef struct packed {
		reg8_t calibration_error_flags;
		reg8_t error_source_flags;
		reg8_t event_flags;
		reg8_t summary_status_byte;
		reg8_t event_flag_mask;
		reg8_t service_request_mask;
		ctrl_rsp_t rsp;
	} state_t;

endpackage

// [hw/status_event_reporting.sv]
// Status and event reporting hierarchy with masks and service request.
// Assumes requests and device events synchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none

module status_event_reporting (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire status_event_pkg::ctrl_req_t req_i,
	input wire status_event_pkg::dev_events_t ev_i,
	output status_event_pkg::ctrl_rsp_t rsp_o,
	output status_event_pkg::reg8_t poll_byte_o,
	output logic srq_o
);
	import status_event_pkg::*;

	state_t s_q;
	state_t s_d;
	logic rd_event;
	logic rd_summary;
	logic rd_cal;
	logic rd_errsrc;
	reg8_t ev_set;
	reg8_t es_set;
	reg8_t sb_live;
	reg8_t ev_next;
	logic srq_now;

	function automatic logic is_cmd(input ctrl_req_t r, input cmd_t c);
		is_cmd = r.valid && (r.cmd == c);
	endfunction

	assign rd_event = is_cmd(req_i, CMD_READ_EVENT);
	assign rd_summary = is_cmd(req_i, CMD_READ_SUMMARY);
	assign rd_cal = is_cmd(req_i, CMD_READ_CAL);
	assign rd_errsrc = is_cmd(req_i, CMD_READ_ERRSRC);

	// ----------------------------------------------------------------
	// Set terms from the device
	// ----------------------------------------------------------------
	always_comb begin
		es_set = REG_ZERO;
		es_set[ES_CAL] = |s_q.calibration_error_flags | (|ev_i.cal_err);
		es_set[ES_CONFLICT] = ev_i.err_conflict;
		es_set[ES_EXEC] = ev_i.err_exec;
		es_set[ES_CMD] = ev_i.err_cmd;
		ev_set = REG_ZERO;
		ev_set[EV_ACQ_DONE] = ev_i.acq_done;
		ev_set[EV_STOP] = ev_i.pretrig_met;
		ev_set[EV_QUERY_ERR] = ev_i.query_err;
		ev_set[EV_CONFLICT] = es_set[ES_CONFLICT];
		ev_set[EV_EXEC_ERR] = es_set[ES_EXEC];
		ev_set[EV_CMD_ERR] = es_set[ES_CMD];
		ev_set[EV_BUF_75] = ev_i.buf_75;
		ev_set[EV_POWER_ON] = ev_i.sys_reset_cmd;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rsp = '{valid: 1'b0, data: REG_ZERO};

		// Read returns old contents then clears; new sets win
		if (rd_cal) begin
			s_d.rsp = '{valid: 1'b1, data: s_q.calibration_error_flags};
		end
		s_d.calibration_error_flags = (rd_cal ? REG_ZERO :
			s_q.calibration_error_flags) | ev_i.cal_err;

		if (rd_errsrc) begin
			s_d.rsp = '{valid: 1'b1, data: s_q.error_source_flags};
		end
		s_d.error_source_flags = (rd_errsrc ? REG_ZERO :
			s_q.error_source_flags) | es_set;

		ev_next = s_q.event_flags;
		if (rd_event) begin
			s_d.rsp = '{valid: 1'b1, data: s_q.event_flags};
			ev_next = REG_ZERO;
		end
		if (ev_i.new_trig_cfg) begin
			ev_next[EV_ACQ_DONE] = 1'b0;
		end
		if (ev_i.new_trig_cfg || ev_i.rearm) begin
			ev_next[EV_STOP] = 1'b0;
		end
		ev_next = ev_next | ev_set;
		ev_next[EV_BUF_75] = ev_i.buf_75;
		s_d.event_flags = ev_next;

		// Summary byte is a live image of conditions and masked events
		sb_live = REG_ZERO;
		sb_live[SB_ALARM] = ev_i.alarm;
		sb_live[SB_TRIG] = ev_i.trig_detected;
		sb_live[SB_READY] = ev_i.ready;
		sb_live[SB_SCAN] = ev_i.scan_avail;
		sb_live[SB_MSG] = ev_i.msg_waiting;
		sb_live[SB_OVERRUN] = ev_i.overrun;
		sb_live[SB_EVENT_SUM] = |(ev_next & s_q.event_flag_mask);
		srq_now = |(sb_live & s_q.service_request_mask &
			~(8'h01 << SB_SRQ));
		sb_live[SB_SRQ] = srq_now;
		if (rd_summary) begin
			s_d.rsp = '{valid: 1'b1, data: s_q.summary_status_byte};
			s_d.summary_status_byte = REG_ZERO;
		end else begin
			s_d.summary_status_byte = sb_live;
		end

		// Masks: read, whole-value write, write of zero clears
		if (is_cmd(req_i, CMD_EVMASK_READ)) begin
			s_d.rsp = '{valid: 1'b1, data: s_q.event_flag_mask};
		end
		if (is_cmd(req_i, CMD_EVMASK_WRITE)) begin
			s_d.event_flag_mask = req_i.data;
		end
		if (is_cmd(req_i, CMD_SRMASK_READ)) begin
			s_d.rsp = '{valid: 1'b1, data: s_q.service_request_mask};
		end
		if (is_cmd(req_i, CMD_SRMASK_WRITE)) begin
			s_d.service_request_mask = req_i.data;
		end

		// System reset command: summary cleared, power-on flag raised
		if (ev_i.sys_reset_cmd) begin
			s_d.summary_status_byte = REG_ZERO;
			s_d.event_flags = s_d.event_flags | EV_RESET_VAL;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			s_q.calibration_error_flags <= REG_ZERO;
			s_q.error_source_flags <= REG_ZERO;
			s_q.event_flags <= EV_RESET_VAL;
			s_q.summary_status_byte <= REG_ZERO;
			s_q.event_flag_mask <= MASK_RESET_VAL;
			s_q.service_request_mask <= MASK_RESET_VAL;
			s_q.rsp <= '{valid: 1'b0, data: REG_ZERO};
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp_o = s_q.rsp;
	assign poll_byte_o = s_q.summary_status_byte;
	assign srq_o = s_q.summary_status_byte[SB_SRQ];

endmodule

`default_nettype wire

// [test/host_ctrl_model.sv]
// Host controller model: issues one command and takes its answer.
// Assumes the block answers on the taking edge, sampled 1 ns after it.
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model (
	input wire logic clk_i,
	input wire status_event_pkg::ctrl_rsp_t rsp_i,
	output status_event_pkg::ctrl_req_t req_o
);
	import status_event_pkg::*;
	initial req_o = '0;
	task automatic xfer(input cmd_t c, input reg8_t d, output ctrl_rsp_t r);
		@(posedge clk_i);
		#1 req_o = '{1'b1, c, d};
		@(posedge clk_i);
		#1 req_o = '{1'b0, CMD_NONE, ~d};
		r = rsp_i;
	endtask
endmodule
`default_nettype wire

// [test/status_event_checker.sv]
// Port checker for the status and event reporting block.
// Bound to the block; sees only its top-level ports.
`timescale 1ns/100ps
`default_nettype none
module status_event_checker (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire status_event_pkg::ctrl_req_t req_i,
	input wire status_event_pkg::dev_events_t ev_i,
	input wire status_event_pkg::ctrl_rsp_t rsp_o,
	input wire status_event_pkg::reg8_t poll_byte_o,
	input wire logic srq_o
);
	import status_event_pkg::*;
	logic rd_c;
	logic clr_c;
	logic sr_wr;
	assign rd_c = req_i.valid && req_i.cmd inside {CMD_READ_EVENT,
		CMD_READ_SUMMARY, CMD_READ_CAL, CMD_READ_ERRSRC,
		CMD_EVMASK_READ, CMD_SRMASK_READ};
	assign clr_c = ev_i.sys_reset_cmd ||
		(req_i.valid && req_i.cmd == CMD_READ_SUMMARY);
	assign sr_wr = req_i.valid && req_i.cmd == CMD_SRMASK_WRITE;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_read_answers:
	assert property (rd_c |=> rsp_o.valid) else $error("no answer");
	a_write_silent:
	assert property (req_i.valid && !rd_c |=> !rsp_o.valid)
		else $error("answer to write");
	a_no_stray_answer:
	assert property (rsp_o.valid |-> $past(rd_c)) else $error("stray answer");
	a_srq_image:
	assert property (srq_o == poll_byte_o[SB_SRQ] && (!srq_o ||
		|(poll_byte_o & ~(8'h01 << SB_SRQ)))) else $error("srq image");
	a_reset_clears:
	assert property (disable iff (1'b0) sys_rst_i |=>
		poll_byte_o == REG_ZERO && !srq_o) else $error("reset clear");
	a_summary_read_clr:
	assert property (clr_c |=> poll_byte_o == REG_ZERO)
		else $error("summary clear");
	a_live_bits:
	assert property (!$past(clr_c) |->
		poll_byte_o[SB_OVERRUN] == $past(ev_i.overrun) &&
		poll_byte_o[SB_ALARM] == $past(ev_i.alarm))
		else $error("live bits");
	a_srq_mask_off:
	assert property (sr_wr && req_i.data == REG_ZERO ##1 !sr_wr |=> !srq_o)
		else $error("srq not off");
	cover property (rd_c && req_i.cmd == CMD_READ_EVENT);
	cover property ($rose(srq_o));
	cover property (clr_c);
endmodule
bind status_event_reporting status_event_checker u_status_event_checker (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
	.ev_i(ev_i), .rsp_o(rsp_o), .poll_byte_o(poll_byte_o), .srq_o(srq_o));
`default_nettype wire

// [test/status_event_reporting_tb.sv]
// Testbench for the status and event reporting block.
// Uses the host controller model for all commands.
`timescale 1ns/100ps
`default_nettype none
module status_event_reporting_tb;
	import status_event_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dev_events_t ev = '0;
	dev_events_t p;
	ctrl_req_t req;
	ctrl_rsp_t rsp;
	reg8_t poll;
	logic srq;
	int miscompares = 0;
	int n_tests = 0;
	status_event_reporting u_status_event_reporting (.sys_clk_i(clk),
		.sys_rst_i(rst), .req_i(req), .ev_i(ev), .rsp_o(rsp),
		.poll_byte_o(poll), .srq_o(srq));
	host_ctrl_model u_host_ctrl_model (.clk_i(clk), .rsp_i(rsp),
		.req_o(req));
	initial forever #2 clk = ~clk;
	task automatic check(input string n, input reg8_t s, input reg8_t e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic summarize();
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic rd(input cmd_t c, input reg8_t e);
		ctrl_rsp_t r;
		u_host_ctrl_model.xfer(c, 8'h00, r);
		check(c.name(), r.valid === 1'b1 ? r.data : ~e, e);
	endtask
	task automatic wr(input cmd_t c, input reg8_t d);
		ctrl_rsp_t r;
		u_host_ctrl_model.xfer(c, d, r);
		check("wr_rsp", {7'h0, r.valid}, 8'h00);
	endtask
	task automatic pulse(input dev_events_t q);
		@(posedge clk);
		#1 ev = dev_events_t'(ev | q);
		@(posedge clk);
		#1 ev = dev_events_t'(ev & ~q);
	endtask
	initial begin
		#10000 miscompares++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		rd(CMD_READ_EVENT, 8'h80);
		rd(CMD_READ_EVENT, 8'h00);
		rd(CMD_EVMASK_READ, 8'h00);
		wr(CMD_EVMASK_WRITE, 8'hff);
		rd(CMD_EVMASK_READ, 8'hff);
		wr(CMD_SRMASK_WRITE, 8'h20);
		rd(CMD_SRMASK_READ, 8'h20);
		for (int i = 0; i < 6; i++) begin
			p = '0;
			case (i)
				0: p.acq_done = 1'b1;
				1: p.pretrig_met = 1'b1;
				2: p.query_err = 1'b1;
				3: p.err_conflict = 1'b1;
				4: p.err_exec = 1'b1;
				default: p.err_cmd = 1'b1;
			endcase
			pulse(p);
			repeat (3) @(posedge clk);
			#1 check("srq", {7'h0, srq}, 8'h01);
			check("esb", poll & 8'h60, 8'h60);
			if (i > 2) rd(CMD_READ_ERRSRC, 8'h01 << (i - 2));
			rd(CMD_READ_EVENT, 8'h01 << i);
			repeat (3) @(posedge clk);
			#1 check("srq_off", {7'h0, srq}, 8'h00);
		end
		pulse('{acq_done: 1'b1, default: 1'b0});
		pulse('{new_trig_cfg: 1'b1, default: 1'b0});
		rd(CMD_READ_EVENT, 8'h00);
		pulse('{pretrig_met: 1'b1, default: 1'b0});
		pulse('{rearm: 1'b1, default: 1'b0});
		rd(CMD_READ_EVENT, 8'h00);
		ev.buf_75 = 1'b1;
		rd(CMD_READ_EVENT, 8'h40);
		rd(CMD_READ_EVENT, 8'h40);
		wr(CMD_SRMASK_WRITE, 8'h00);
		repeat (3) @(posedge clk);
		#1 check("srq_mask", {7'h0, srq}, 8'h00);
		ev.buf_75 = 1'b0;
		rd(CMD_READ_EVENT, 8'h00);
		ev.alarm = 1'b1;
		ev.msg_waiting = 1'b1;
		repeat (2) @(posedge clk);
		#1 check("poll_live", poll, 8'h11);
		rd(CMD_READ_SUMMARY, 8'h11);
		check("poll_clr", poll, 8'h00);
		pulse('{sys_reset_cmd: 1'b1, default: 1'b0});
		rd(CMD_READ_EVENT, 8'h80);
		pulse('{cal_err: 8'h05, default: 1'b0});
		rd(CMD_READ_ERRSRC, 8'h01);
		rd(CMD_READ_CAL, 8'h05);
		summarize();
	end
endmodule
`default_nettype wire
